// ==== hw/stream_hdr_defs.svh ====
// Field positions, widths and counts for the streaming sublayer header transmitter.
// Assumes one 32-bit header word followed by one 32-bit word per segment-table entry.
`ifndef STREAM_HDR_DEFS_SVH
`define STREAM_HDR_DEFS_SVH
`define HDR_CCV_POS 31
`define HDR_SEQOK_POS 30
`define HDR_EXT_HI 29
`define HDR_EXT_LO 28
`define HDR_EXT_VAL 2'h0
`define HDR_FLOW_HI 27
`define HDR_FLOW_LO 25
`define HDR_RSV_POS 24
`define HDR_CNT_HI 22
`define HDR_CNT_LO 16
`define HDR_SEQ_HI 15
`define HDR_SEQ_LO 0
`define ENT_BEGIN_POS 31
`define ENT_END_POS 30
`define ENT_LEN_HI 29
`define ENT_LEN_LO 16
`define ENT_CHAN_HI 15
`define ENT_CHAN_LO 8
`define ENT_CSEQ_HI 7
`define ENT_CSEQ_LO 4
`define ENT_PROF_HI 3
`define ENT_PROF_LO 0
`define PROF_MSG_BLOCK 4'h1
`define PROF_ZERO 4'h0
`define MAX_SEGS 7'h7F
`define FIFO_DEPTH 32
`define FIFO_WIDTH 33
`define SEQ_SEED 16'hACE1
`define CLR_LAST 11'h7FF
`endif

// ==== hw/stream_hdr_pkg.sv ====
// Types shared by the streaming sublayer header transmitter.
// Assumes the constants come from stream_hdr_defs.svh.
package stream_hdr_pkg;
   typedef enum logic [4:0] {
      st_clr = 5'h01,
      st_idle = 5'h02,
      st_hdr = 5'h04,
      st_tab = 5'h08,
      st_pay = 5'h10
   } state_e;
   typedef logic [31:0] word_t;
endpackage : stream_hdr_pkg

// ==== hw/stream_header_tx.sv ====
// Core-side transmitter: builds header and segment table, then forwards payload.
// Assumes a user that pushes entries, then a packet request, then payload words.
`timescale 1ns/1ps
`include "stream_hdr_defs.svh"

module word_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 32,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [AW:0] level
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Output stage is a register so the link sees flop-driven signals
   assign in_ready = (count != (AW+1)'(DEPTH));
   assign push = in_valid && in_ready;
   assign pop = (count != '0) && (!out_valid || out_ready);
   assign level = count;

   // Storage needs no reset; pointers guard it
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers and fill level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Output register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_valid <= 1'b0;
         out_data <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_data <= mem[rd_ptr];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end
endmodule : word_fifo

module stream_header_tx import stream_hdr_pkg::*; (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ent_valid,
   output logic ent_ready,
   input wire logic [13:0] ent_length,
   input wire logic [7:0] ent_channel,
   input wire logic [3:0] ent_profile,
   input wire logic ent_block,
   input wire logic ent_link,
   input wire logic ent_begin,
   input wire logic ent_end,
   input wire logic pkt_valid,
   output logic pkt_ready,
   input wire logic [2:0] pkt_flow,
   output logic pkt_done,
   output logic pkt_error,
   input wire logic pay_valid,
   output logic pay_ready,
   input wire logic [31:0] pay_data,
   input wire logic pay_last,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [31:0] tx_data,
   output logic tx_last
);
   state_e state;
   state_e next_state;
   word_t table_mem [128];
   logic [3:0] cseq_mem [2048];
   logic [15:0] seq_mem [8];
   logic [7:0] seq_live;
   logic [15:0] lfsr;
   logic [10:0] clr_idx;
   logic [6:0] ent_cnt;
   logic [6:0] cnt_total;
   logic [6:0] hdr_cnt;
   logic [6:0] tab_idx;
   logic [2:0] flow;
   logic seen_data;
   logic open_data;
   logic bad;
   logic next_bad;
   logic ent_fire;
   logic pkt_fire;
   logic pay_fire;
   word_t ent_word;
   word_t hdr_word;
   word_t tab_word;
   logic [15:0] seq_cur;
   logic [10:0] cseq_idx;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [32:0] fifo_in_data;
   logic [32:0] fifo_out_data;
   logic [5:0] fifo_level;

   assign ent_fire = ent_valid && ent_ready;
   assign pkt_fire = pkt_valid && pkt_ready;
   assign pay_fire = pay_valid && pay_ready;
   assign cnt_total = ent_cnt + 7'(ent_fire);
   assign tx_data = fifo_out_data[31:0];
   assign tx_last = fifo_out_data[32];

   // Format an entry as it is pushed; channel sequence is filled at send time
   always_comb begin
      ent_word = '0;
      ent_word[`ENT_LEN_HI:`ENT_LEN_LO] = ent_length;
      ent_word[`ENT_CHAN_HI:`ENT_CHAN_LO] = ent_channel;
      if (ent_block) begin
         ent_word[`ENT_BEGIN_POS] = ent_begin; // Timestamp present
         ent_word[`ENT_END_POS] = 1'b0;
         ent_word[`ENT_PROF_HI:`ENT_PROF_LO] = `PROF_MSG_BLOCK; // Whole block, one entry
      end else begin
         ent_word[`ENT_BEGIN_POS] = ent_begin;
         ent_word[`ENT_END_POS] = ent_end;
         if (ent_link || !ent_begin) begin
            ent_word[`ENT_PROF_HI:`ENT_PROF_LO] = `PROF_ZERO;
         end else begin
            ent_word[`ENT_PROF_HI:`ENT_PROF_LO] = ent_profile;
         end
      end
   end

   // Only the first data entry may continue a frame, only the last may leave one open
   always_comb begin
      next_bad = bad;
      if (ent_fire && !ent_block && ((seen_data && !ent_begin) || open_data)) begin
         next_bad = 1'b1;
      end
   end

   // Sequence start is random the first time a flow is used
   assign seq_cur = seq_live[flow] ? seq_mem[flow] : lfsr;

   // One header layout for every channel kind
   always_comb begin
      hdr_word = '0;
      hdr_word[`HDR_CCV_POS] = 1'b0;
      hdr_word[`HDR_SEQOK_POS] = 1'b1; // Sequence always carried
      hdr_word[`HDR_EXT_HI:`HDR_EXT_LO] = `HDR_EXT_VAL;
      hdr_word[`HDR_FLOW_HI:`HDR_FLOW_LO] = flow;
      hdr_word[`HDR_RSV_POS] = 1'b0;
      hdr_word[`HDR_CNT_HI:`HDR_CNT_LO] = hdr_cnt;
      hdr_word[`HDR_SEQ_HI:`HDR_SEQ_LO] = seq_cur;
   end

   // Table word with the per-channel sequence inserted
   assign cseq_idx = {flow, table_mem[tab_idx][`ENT_CHAN_HI:`ENT_CHAN_LO]};
   always_comb begin
      tab_word = table_mem[tab_idx]; // 32-bit entries only
      tab_word[`ENT_CSEQ_HI:`ENT_CSEQ_LO] = cseq_mem[cseq_idx];
   end

   // FIFO input selection by state
   always_comb begin
      fifo_in_valid = 1'b0;
      fifo_in_data = '0;
      case (state)
         st_hdr: begin
            fifo_in_valid = 1'b1;
            fifo_in_data = {1'b0, hdr_word};
         end
         st_tab: begin
            fifo_in_valid = 1'b1;
            fifo_in_data = {1'b0, tab_word};
         end
         st_pay: begin
            fifo_in_valid = pay_fire;
            fifo_in_data = {pay_last, pay_data};
         end
         default: begin
            fifo_in_valid = 1'b0;
         end
      endcase
   end

   // Sequencer
   always_comb begin
      next_state = state;
      case (state)
         st_clr: begin
            if (clr_idx == `CLR_LAST) begin
               next_state = st_idle;
            end
         end
         st_idle: begin
            if (pkt_fire && !next_bad && cnt_total != 7'h00) begin
               next_state = st_hdr;
            end
         end
         st_hdr: begin
            if (fifo_in_ready) begin
               next_state = st_tab;
            end
         end
         st_tab: begin
            if (fifo_in_ready && tab_idx == hdr_cnt - 7'h01) begin
               next_state = st_pay;
            end
         end
         st_pay: begin
            if (pay_fire && pay_last) begin
               next_state = st_idle;
            end
         end
         default: begin
            next_state = st_clr;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= st_clr;
      end else begin
         state <= next_state;
      end
   end

   // Sweep clears channel sequences after reset; avoids a 2048-entry reset tree
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clr_idx <= '0;
      end else if (state == st_clr) begin
         clr_idx <= clr_idx + 11'h001;
      end
   end

   // Channel sequence per flow and channel, bumped as each entry leaves
   always_ff @(posedge clk) begin
      if (state == st_clr) begin
         cseq_mem[clr_idx] <= 4'h0;
      end else if (state == st_tab && fifo_in_ready) begin
         cseq_mem[cseq_idx] <= cseq_mem[cseq_idx] + 4'h1;
      end
   end

   // Entry table storage
   always_ff @(posedge clk) begin
      if (ent_fire) begin
         table_mem[ent_cnt] <= ent_word;
      end
   end

   // Entry collection and split checks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ent_cnt <= '0;
         seen_data <= 1'b0;
         open_data <= 1'b0;
         bad <= 1'b0;
      end else if (pkt_fire) begin
         ent_cnt <= '0;
         seen_data <= 1'b0;
         open_data <= 1'b0;
         bad <= 1'b0;
      end else if (ent_fire) begin
         ent_cnt <= cnt_total;
         bad <= next_bad;
         if (!ent_block) begin
            seen_data <= 1'b1;
            open_data <= !ent_end;
         end
      end
   end

   // Latch packet parameters and walk the table
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flow <= '0;
         hdr_cnt <= '0;
         tab_idx <= '0;
      end else if (state == st_idle && pkt_fire) begin
         flow <= pkt_flow;
         hdr_cnt <= cnt_total;
         tab_idx <= '0;
      end else if (state == st_tab && fifo_in_ready) begin
         tab_idx <= tab_idx + 7'h01;
      end
   end

   // Free-running scrambler gives unpredictable start values
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lfsr <= `SEQ_SEED;
      end else begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
   end

   // Per-flow packet sequence
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seq_live <= '0;
      end else if (state == st_hdr && fifo_in_ready) begin
         seq_live[flow] <= 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (state == st_hdr && fifo_in_ready) begin
         seq_mem[flow] <= seq_cur + 16'h0001;
      end
   end

   // Registered handshakes; payload ready keeps one FIFO slot of margin
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ent_ready <= 1'b0;
         pkt_ready <= 1'b0;
         pay_ready <= 1'b0;
      end else begin
         ent_ready <= (next_state == st_idle) && !pkt_fire && (cnt_total != `MAX_SEGS);
         pkt_ready <= (next_state == st_idle) && !pkt_fire;
         pay_ready <= (next_state == st_pay) && !(pay_fire && pay_last)
                      && (fifo_level < 6'(`FIFO_DEPTH - 1));
      end
   end

   // Completion and refusal pulses
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pkt_done <= 1'b0;
         pkt_error <= 1'b0;
      end else begin
         pkt_done <= pay_fire && pay_last;
         pkt_error <= pkt_fire && (next_bad || cnt_total == 7'h00);
      end
   end

   word_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(`FIFO_DEPTH),
      .AW(5)
   ) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );
endmodule : stream_header_tx

// ==== testbench/stream_header_tx_chk.sv ====
// Checker for the header transmitter: header fields and handshake timing.
// Assumes it is bound to stream_header_tx and sees only its ports.
`timescale 1ns/1ps
module stream_header_tx_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic pkt_valid,
   input wire logic pkt_ready,
   input wire logic pkt_error,
   input wire logic ent_ready,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [31:0] tx_data,
   input wire logic tx_last
);
   logic hdr;
   // Marks the word that opens each packet
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) hdr <= 1'b1;
      else if (tx_valid && tx_ready) hdr <= tx_last;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_ccv; tx_valid && hdr |-> !tx_data[31]; endproperty
   a_ccv: assert property (p_ccv) else $error("check flag set");
   property p_seqok; tx_valid && hdr |-> tx_data[30]; endproperty
   a_seqok: assert property (p_seqok) else $error("sequence flag clear");
   property p_ext; tx_valid && hdr |-> tx_data[29:28] == 2'h0; endproperty
   a_ext: assert property (p_ext) else $error("extended bits set");
   property p_rsv; tx_valid && hdr |-> tx_data[24:23] == 2'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
   property p_cnt; tx_valid && hdr |-> tx_data[22:16] != 7'h00; endproperty
   a_cnt: assert property (p_cnt) else $error("empty table sent");
   // Output word must not change while the node stalls
   property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last); endproperty
   a_hold: assert property (p_hold) else $error("word changed in stall");
   property p_err; pkt_error |-> $past(pkt_valid && pkt_ready) ##1 !pkt_error; endproperty
   a_err: assert property (p_err) else $error("stray refusal");
   property p_fire; pkt_valid && pkt_ready |=> !ent_ready; endproperty
   a_fire: assert property (p_fire) else $error("entry open after fire");
endmodule : stream_header_tx_chk

bind stream_header_tx stream_header_tx_chk stream_header_tx_chk_inst (.clk(clk), .rstn(rstn),
   .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_error(pkt_error), .ent_ready(ent_ready),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));

// ==== testbench/node_rx_model.sv ====
// Receiving node model: takes the word stream, tracks sequence per flow.
// Assumes the bench reads rxq and gaps by hierarchy and drives stall.
`timescale 1ns/1ps
module node_rx_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic stall,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [31:0] tx_data,
   input wire logic tx_last
);
   logic [32:0] rxq[$];
   logic [15:0] last_seq [8];
   logic [7:0] seen;
   logic in_hdr;
   int gaps = 0;
   // Table walk: entries left, summed lengths and payload bytes per packet; closed frames counted over the whole run
   logic [6:0] ent_left;
   int len_sum = 0, pay_bytes = 0, frames_done = 0;
   // Registered ready, so a stall lags one cycle like a real node
   always @(posedge clk or negedge rstn) begin
      if (!rstn) tx_ready <= 1'b0;
      else tx_ready <= !stall;
   end
   // One parser for every channel kind; reserved bit never looked at
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_hdr <= 1'b1;
         seen <= 8'h00;
         ent_left <= 7'h00;
      end else if (tx_valid && tx_ready) begin
         // Sums are updated before the push so the bench never sees a stale total
         if (in_hdr) begin
            ent_left <= tx_data[22:16];
            len_sum = 0;
            pay_bytes = 0;
         end else if (ent_left != 7'h00) begin
            ent_left <= ent_left - 7'h01;
            len_sum = len_sum + tx_data[29:16];
            if (tx_data[30]) frames_done++; // Frame closed; blocks always send end as zero
         end else begin
            pay_bytes = pay_bytes + 4;
         end
         rxq.push_back({tx_last, tx_data});
         in_hdr <= tx_last;
         if (in_hdr && tx_data[30]) begin
            if (seen[tx_data[27:25]] && tx_data[15:0] !== last_seq[tx_data[27:25]] + 16'h1) gaps++;
            last_seq[tx_data[27:25]] <= tx_data[15:0];
            seen[tx_data[27:25]] <= 1'b1;
         end
      end
   end
endmodule : node_rx_model

// ==== testbench/tb_stream_header_tx.sv ====
// Bench for the header transmitter: packets, refusals and a full buffer.
// Assumes the node model and the bound checker are compiled before it.
`timescale 1ns/1ps
module tb_stream_header_tx;
   logic clk = 1'b0, rstn = 1'b0, stall = 1'b0;
   logic ent_valid = 1'b0, ent_block = 1'b0, ent_link = 1'b0, ent_begin = 1'b0, ent_end = 1'b0;
   logic [13:0] ent_length = 14'h0;
   logic [7:0] ent_channel = 8'h0;
   logic [3:0] ent_profile = 4'h0;
   logic pkt_valid = 1'b0, pay_valid = 1'b0, pay_last = 1'b0;
   logic [2:0] pkt_flow = 3'h0;
   logic [31:0] pay_data = 32'h0;
   logic ent_ready, pkt_ready, pkt_done, pkt_error, pay_ready, tx_valid, tx_ready, tx_last;
   logic [31:0] tx_data;
   logic [3:0] cseq [0:2047];
   logic [15:0] sq [8];
   int bad_count = 0, total_checks = 0, rx_i = 0, refused = 0;
   // Clock
   always #2.5 clk = ~clk;
   stream_header_tx stream_header_tx_inst (.clk(clk), .rstn(rstn), .ent_valid(ent_valid),
      .ent_ready(ent_ready), .ent_length(ent_length), .ent_channel(ent_channel),
      .ent_profile(ent_profile), .ent_block(ent_block), .ent_link(ent_link), .ent_begin(ent_begin),
      .ent_end(ent_end), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt_flow(pkt_flow),
      .pkt_done(pkt_done), .pkt_error(pkt_error), .pay_valid(pay_valid), .pay_ready(pay_ready),
      .pay_data(pay_data), .pay_last(pay_last), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .tx_last(tx_last));
   node_rx_model node_rx_model_inst (.clk(clk), .rstn(rstn), .stall(stall), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));
   task check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   // Kind is {block, link, begin, end}
   task push_ent(input logic [13:0] len, input logic [7:0] ch, input logic [3:0] pf, input logic [3:0] kind);
      @(posedge clk);
      ent_valid <= 1'b1;
      ent_length <= len;
      ent_channel <= ch;
      ent_profile <= pf;
      {ent_block, ent_link, ent_begin, ent_end} <= kind;
      do @(posedge clk); while (!ent_ready);
      ent_valid <= 1'b0;
   endtask : push_ent
   task send_pkt(input logic [2:0] fl, input logic err);
      @(posedge clk);
      pkt_valid <= 1'b1;
      pkt_flow <= fl;
      do @(posedge clk); while (!pkt_ready);
      pkt_valid <= 1'b0;
      @(posedge clk);
      check({31'h0, pkt_error}, {31'h0, err});
   endtask : send_pkt
   task send_pay(input int n, input logic [31:0] base);
      for (int i = 0; i < n; i++) begin
         pay_valid <= 1'b1;
         pay_data <= base + i;
         pay_last <= (i == n - 1);
         // Only stalls after the first word count; the start-up wait is not a refusal
         do begin
            @(posedge clk);
            if (!pay_ready && i > 0) refused++;
         end while (!pay_ready);
      end
      pay_valid <= 1'b0;
      repeat (300) begin
         @(posedge clk);
         if (pkt_done) break;
      end
      check({31'h0, pkt_done}, 32'h1);
   endtask : send_pay
   task wait_rx;
      repeat (500) begin
         if (node_rx_model_inst.rxq.size() > rx_i) break;
         @(posedge clk);
      end
   endtask : wait_rx
   task exp_word(input logic [31:0] e, input logic l);
      wait_rx;
      check(node_rx_model_inst.rxq[rx_i][31:0], e);
      check({31'h0, node_rx_model_inst.rxq[rx_i][32]}, {31'h0, l});
      rx_i++;
   endtask : exp_word
   // First packet on a flow takes its random start, later ones add one
   task exp_hdr(input logic [2:0] fl, input logic [6:0] cnt, input logic first);
      wait_rx;
      if (first) sq[fl] = node_rx_model_inst.rxq[rx_i][15:0];
      else sq[fl] = sq[fl] + 16'h1;
      exp_word({4'h4, fl, 2'b00, cnt, sq[fl]}, 1'b0);
   endtask : exp_hdr
   task exp_ent(input logic [1:0] be, input logic [13:0] len, input logic [7:0] ch, input logic [2:0] fl,
      input logic [3:0] pf);
      exp_word({be, len, ch, cseq[{fl, ch}], pf}, 1'b0);
      cseq[{fl, ch}] = cseq[{fl, ch}] + 4'h1;
   endtask : exp_ent
   task t_whole;
      push_ent(14'h8, 8'h03, 4'h5, 4'b0011);
      send_pkt(3'h2, 1'b0);
      send_pay(2, 32'hA000);
      exp_hdr(3'h2, 7'h1, 1'b1);
      exp_ent(2'b11, 14'h8, 8'h03, 3'h2, 4'h5);
      exp_word(32'hA000, 1'b0);
      exp_word(32'hA001, 1'b1);
      check(node_rx_model_inst.len_sum, 32'h8);
      check(node_rx_model_inst.pay_bytes, 32'h8);
   endtask : t_whole
   task t_mixed;
      push_ent(14'h10, 8'h03, 4'h7, 4'b0001);
      push_ent(14'h20, 8'h09, 4'h3, 4'b1011);
      push_ent(14'h30, 8'h09, 4'h6, 4'b0110);
      push_ent(14'h18, 8'h0A, 4'hF, 4'b1001);
      send_pkt(3'h2, 1'b0);
      send_pay(3, 32'hB000);
      exp_hdr(3'h2, 7'h4, 1'b0);
      exp_ent(2'b01, 14'h10, 8'h03, 3'h2, 4'h0);
      exp_ent(2'b10, 14'h20, 8'h09, 3'h2, 4'h1);
      exp_ent(2'b10, 14'h30, 8'h09, 3'h2, 4'h0);
      exp_ent(2'b00, 14'h18, 8'h0A, 3'h2, 4'h1);
      for (int i = 0; i < 3; i++) exp_word(32'hB000 + i, i == 2);
   endtask : t_mixed
   task t_refuse;
      send_pkt(3'h1, 1'b1);
      push_ent(14'h8, 8'h01, 4'h0, 4'b0010);
      push_ent(14'h8, 8'h01, 4'h0, 4'b0011);
      send_pkt(3'h1, 1'b1);
      repeat (10) @(posedge clk);
      check(node_rx_model_inst.rxq.size(), rx_i);
      push_ent(14'h8, 8'h01, 4'h0, 4'b0011);
      send_pkt(3'h1, 1'b0);
      send_pay(1, 32'hC000);
      exp_hdr(3'h1, 7'h1, 1'b1);
      exp_ent(2'b11, 14'h8, 8'h01, 3'h1, 4'h0);
      exp_word(32'hC000, 1'b1);
   endtask : t_refuse
   // Node stalls from before the entry push until 80 cycles after the request, so the buffer refuses payload, then drains it
   task t_fill;
      stall <= 1'b1;
      refused = 0;
      push_ent(14'h4, 8'h05, 4'h2, 4'b0011);
      send_pkt(3'h5, 1'b0);
      fork
         send_pay(40, 32'hD000);
         begin
            repeat (80) @(posedge clk);
            stall <= 1'b0;
         end
      join
      check({31'h0, refused > 0}, 32'h1);
      exp_hdr(3'h5, 7'h1, 1'b1);
      exp_ent(2'b11, 14'h4, 8'h05, 3'h5, 4'h2);
      for (int i = 0; i < 40; i++) exp_word(32'hD000 + i, i == 39);
   endtask : t_fill
   // Main sequence
   initial begin
      foreach (cseq[i]) cseq[i] = 4'h0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (3000) begin
         @(posedge clk);
         if (ent_ready) break;
      end
      t_whole;
      t_mixed;
      t_refuse;
      t_fill;
      check(node_rx_model_inst.gaps, 32'h0);
      check(node_rx_model_inst.frames_done, 32'h4);
      finish_test;
   end
   // Watchdog
   initial begin
      #100000;
      bad_count++;
      finish_test;
   end
endmodule : tb_stream_header_tx
